// File: logic/rx_link_status_pkg.sv
package rx_link_status_pkg;

  // Word-index offsets; the byte address is four times the index.
  localparam logic [9:0] FAULT_REPORT_IDX      = 10'h308;
  localparam logic [9:0] RECOVERED_CLK_LCK_IDX = 10'h321;
  localparam logic [9:0] FRAME_ERR_STATUS_IDX  = 10'h323;
  localparam logic [9:0] FRAME_ERR_CLEAR_IDX   = 10'h324;
  localparam logic [9:0] RX_ALIGN_STATUS_IDX   = 10'h326;
  localparam logic [9:0] PMA_FLAG_SELECT_IDX   = 10'h330;
  localparam logic [9:0] PMA_FLAGS_IDX         = 10'h331;
  localparam logic [9:0] LINK_CONTROL_IDX      = 10'h332;

  // Lane count and field positions.
  localparam int          NUM_LANES          = 4;
  localparam int          ALIGN_BIT          = 0;
  localparam int          LOCAL_FAULT_BIT    = 0;
  localparam int          FAULT_GEN_EN_BIT   = 0;

  // Reset values.
  localparam logic [31:0] SELECT_RESET       = 32'h0000_0000;
  localparam logic        CLEAR_RESET        = 1'b0;
  localparam logic        FAULT_GEN_RESET    = 1'b1;

  // Soft reset pulse length: 100 ns at 200 MHz, longest time so round down.
  localparam int          CLK_PERIOD_PS      = 5000;
  localparam int          SOFT_RST_NS        = 100;
  localparam int          SOFT_RST_CYCLES    = (SOFT_RST_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [7:0]  SOFT_RST_COUNT     = 8'(SOFT_RST_CYCLES);

  // PMA FIFO level flags of one lane.
  typedef struct packed {
    logic txFull;
    logic txEmpty;
    logic rxFull;
    logic rxEmpty;
  } pma_flags_t;

  // Receive lane status that travels together.
  typedef struct packed {
    logic [NUM_LANES-1:0] wordLock;
    logic [NUM_LANES-1:0] frameErr;
    logic [NUM_LANES-1:0] clockLock;
  } lane_status_t;

  typedef enum logic [1:0] {
    LINK_DOWN,
    LINK_UP,
    LINK_LOST
  } link_state_t;

endpackage

// File: logic/sticky_bit.sv
`timescale 1ns/1ps
module sticky_bit
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic resetN,
  // Event and clear.
  input  wire logic setEvent,
  input  wire logic holdClear,
  // Sticky value.
  output logic      value
);

  // Clear holds the flag low; an event in the cycle the clear drops is kept.
  always_ff @(posedge clk)
  begin
    if (!resetN)
      value <= 1'b0;
    else if (holdClear)
      value <= 1'b0;
    else if (setEvent)
      value <= 1'b1;
  end

endmodule

// File: logic/rx_link_status_monitor.sv
// The APB slave port was decided locally.
`timescale 1ns/1ps
// What this block does
// - Status reads zero after clear under lock
// - Clock lock bits reflect lane recovery
// - Flag select chooses shown PMA flags
// - RX FIFO full and TX extremes are faults
// - Loss of signal leaves transmit untouched
// - Marker lock loss drops aligned-ready
// - Alignment status bit follows aligned-ready
// - Fault option drives local fault on loss
// - Fault report bit tracks local fault
// - Loss of signal requests RX soft reset
module rx_link_status_monitor
  import rx_link_status_pkg::*;
(
  // Clock and reset.
  input  wire logic                            core_clk,
  input  wire logic                            reset_n,
  // APB slave.
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [11:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Receive path status.
  input  wire rx_link_status_pkg::lane_status_t laneStatus,
  input  wire logic                            markerLock,
  input  wire logic                            signalDetect,
  input  wire rx_link_status_pkg::pma_flags_t [rx_link_status_pkg::NUM_LANES-1:0] pmaFlags,
  // Link status outputs.
  output logic                                 rxPcsReady,
  output logic                                 localFaultStatus,
  output logic                                 rxSoftResetReq,
  output logic                                 fifoFault
);
  import rx_link_status_pkg::*;

  logic [31:0]          flagSelect_reg;
  logic                 frameClear_reg;
  logic                 faultGenEn_reg;
  logic [NUM_LANES-1:0] frameErrSticky;
  logic                 rxPcsReady_reg;
  logic                 localFault_reg;
  logic                 softRst_reg;
  logic [7:0]           softCnt_reg;
  logic [31:0]          prdata_reg;
  link_state_t          linkState_reg;
  link_state_t          linkState_next;
  logic                 accessPhase;
  logic                 writeTake;
  logic [9:0]           wordIdx;
  logic                 mapped;
  logic [31:0]          readValue;
  logic [31:0]          flagView;
  logic                 signalLost;

  assign accessPhase = psel && penable;
  assign writeTake   = accessPhase && pwrite;
  assign wordIdx     = paddr[11:2];
  assign signalLost  = !signalDetect || !markerLock;

  // The slave answers in the first access cycle, so there are no wait states.
  assign pready  = accessPhase;
  assign pslverr = accessPhase && !mapped;

  // Writable control registers; the clear is level held, not self clearing.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      flagSelect_reg <= SELECT_RESET;
      frameClear_reg <= CLEAR_RESET;
      faultGenEn_reg <= FAULT_GEN_RESET;
    end
    else if (writeTake)
    begin
      case (wordIdx)
        FRAME_ERR_CLEAR_IDX: frameClear_reg <= pwdata[0];
        PMA_FLAG_SELECT_IDX: flagSelect_reg <= pwdata;
        LINK_CONTROL_IDX:    faultGenEn_reg <= pwdata[FAULT_GEN_EN_BIT];
        default:             flagSelect_reg <= flagSelect_reg;
      endcase
    end
  end

  // One sticky error bit per lane; a framing error or a loss of word lock on the lane sets it.
  genvar lane;
  generate
    for (lane = 0; lane < NUM_LANES; lane++)
    begin : gen_frame_err
      sticky_bit frameErrBit
      (
        .clk       (core_clk),
        .resetN    (reset_n),
        .setEvent  (laneStatus.frameErr[lane] || !laneStatus.wordLock[lane]),
        .holdClear (frameClear_reg),
        .value     (frameErrSticky[lane])
      );
    end
  endgenerate

  // Link state: loss of signal takes the receive path down; transmit has no input here.
  always_comb
  begin
    linkState_next = linkState_reg;
    case (linkState_reg)
      LINK_DOWN: if (!signalLost) linkState_next = LINK_UP;
      LINK_UP:   if (signalLost) linkState_next = LINK_LOST;
      LINK_LOST: if (softCnt_reg == 8'h00) linkState_next = LINK_DOWN;
      default:   linkState_next = LINK_DOWN;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      linkState_reg <= LINK_DOWN;
    else
      linkState_reg <= linkState_next;
  end

  // Aligned-ready follows signal detect and marker lock directly so it drops one edge after loss of either.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      rxPcsReady_reg <= 1'b0;
    else
      rxPcsReady_reg <= !signalLost;
  end

  // Local fault rises on loss only when generation is enabled.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      localFault_reg <= 1'b0;
    else
      localFault_reg <= signalLost && faultGenEn_reg;
  end

  // Soft reset request pulses for a fixed count on entering the lost state.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      softRst_reg <= 1'b0;
      softCnt_reg <= 8'h00;
    end
    else if (linkState_reg == LINK_UP && signalLost)
    begin
      softRst_reg <= 1'b1;
      softCnt_reg <= SOFT_RST_COUNT - 8'h01;
    end
    else if (softCnt_reg != 8'h00)
      softCnt_reg <= softCnt_reg - 8'h01;
    else
      softRst_reg <= 1'b0;
  end

  assign rxPcsReady       = rxPcsReady_reg;
  assign localFaultStatus = localFault_reg;
  assign rxSoftResetReq   = softRst_reg;

  // RX FIFO full, or TX at either extreme, on any lane is a fault.
  always_comb
  begin
    fifoFault = 1'b0;
    for (int i = 0; i < NUM_LANES; i++)
      fifoFault = fifoFault || pmaFlags[i].rxFull || pmaFlags[i].txFull
                  || pmaFlags[i].txEmpty;
  end

  // Flag view: select bit i enables the four flags of lane i.
  always_comb
  begin
    flagView = 32'h0000_0000;
    for (int i = 0; i < NUM_LANES; i++)
      if (flagSelect_reg[i])
        flagView[i*4 +: 4] = pmaFlags[i];
  end

  // Read mux; unmapped addresses read zero and flag an error.
  always_comb
  begin
    readValue = 32'h0000_0000;
    mapped    = 1'b1;
    case (wordIdx)
      FAULT_REPORT_IDX:      readValue[LOCAL_FAULT_BIT] = localFault_reg;
      RECOVERED_CLK_LCK_IDX: readValue[NUM_LANES-1:0] = laneStatus.clockLock;
      FRAME_ERR_STATUS_IDX:  readValue[NUM_LANES-1:0] = frameErrSticky;
      FRAME_ERR_CLEAR_IDX:   readValue[0] = frameClear_reg;
      RX_ALIGN_STATUS_IDX:   readValue[ALIGN_BIT] = rxPcsReady_reg;
      PMA_FLAG_SELECT_IDX:   readValue = flagSelect_reg;
      PMA_FLAGS_IDX:         readValue = flagView;
      LINK_CONTROL_IDX:      readValue[FAULT_GEN_EN_BIT] = faultGenEn_reg;
      default:               mapped = 1'b0;
    endcase
  end

  // Read data registered during setup so it is stable in the access phase.
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      prdata_reg <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata_reg <= readValue;
  end

  assign prdata = prdata_reg;

  // Checks beside the logic.
  ready_drop_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !markerLock |=> !rxPcsReady)
    else $error("aligned-ready stayed high after marker loss");

  fault_gen_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!signalDetect && faultGenEn_reg) |=> localFaultStatus)
    else $error("local fault missing on loss of signal");

  fault_off_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!signalLost || !faultGenEn_reg) |=> !localFaultStatus)
    else $error("local fault raised without cause");

  sequence lossSeen;
    linkState_reg == LINK_UP ##0 signalLost;
  endsequence

  soft_rst_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    lossSeen |=> rxSoftResetReq [*8])
    else $error("soft reset request too short");

  align_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accessPhase && !pwrite && wordIdx == RX_ALIGN_STATUS_IDX)
      |-> prdata[ALIGN_BIT] == $past(rxPcsReady))
    else $error("alignment status disagrees with aligned-ready");

  fault_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accessPhase && !pwrite && wordIdx == FAULT_REPORT_IDX)
      |-> prdata[LOCAL_FAULT_BIT] == $past(localFaultStatus))
    else $error("fault report disagrees with local fault");

  clear_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    frameClear_reg |=> frameErrSticky == '0)
    else $error("frame error not cleared while clear held");

  sticky_keep_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (frameErrSticky[0] && !frameClear_reg) |=> frameErrSticky[0])
    else $error("frame error bit dropped without clear");

  lock_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (accessPhase && !pwrite && wordIdx == RECOVERED_CLK_LCK_IDX)
      |-> prdata[NUM_LANES-1:0] == $past(laneStatus.clockLock))
    else $error("clock lock read mismatch");

  fifo_fault_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    pmaFlags[0].rxFull |-> fifoFault)
    else $error("RX FIFO full not flagged");

endmodule

// File: bench/link_partner_model.sv
`timescale 1ns/1ps
module link_partner_model
  import rx_link_status_pkg::*;
(
  // Commands from the bench.
  input  wire logic                                                dropSig,
  input  wire logic                                                dropMarker,
  input  wire logic [rx_link_status_pkg::NUM_LANES-1:0]            errLanes,
  input  wire logic [rx_link_status_pkg::NUM_LANES-1:0]            unlockLanes,
  input  wire logic [rx_link_status_pkg::NUM_LANES-1:0]            badClk,
  input  wire rx_link_status_pkg::pma_flags_t [rx_link_status_pkg::NUM_LANES-1:0] flagsCmd,
  // Lane state as seen by the receiver.
  output rx_link_status_pkg::lane_status_t                         laneStatus,
  output logic                                                     markerLock,
  output logic                                                     signalDetect,
  output rx_link_status_pkg::pma_flags_t [rx_link_status_pkg::NUM_LANES-1:0] pmaFlags
);
  import rx_link_status_pkg::*;

  // A healthy partner keeps every lane locked; commands only take health away.
  assign laneStatus = '{wordLock: ~unlockLanes, frameErr: errLanes, clockLock: ~badClk};
  assign markerLock = ~dropMarker;
  assign signalDetect = ~dropSig;
  assign pmaFlags = flagsCmd;
endmodule

// File: bench/rx_link_status_monitor_tb_top.sv
`timescale 1ns/1ps
module rx_link_status_monitor_tb_top;
  import rx_link_status_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, markerLock, signalDetect;
  logic rxPcsReady, localFaultStatus, rxSoftResetReq, fifoFault;
  logic dropSig = 1'b0, dropMarker = 1'b0;
  logic [NUM_LANES-1:0] errLanes = '0, unlockLanes = '0, badClk = '0;
  pma_flags_t [NUM_LANES-1:0] flagsCmd = '0, pmaFlags;
  lane_status_t laneStatus;
  int error_cnt = 0, compares = 0;

  // Design and the remote partner that feeds its lane status.
  rx_link_status_monitor rx_link_status_monitor_i (.core_clk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .laneStatus, .markerLock,
    .signalDetect, .pmaFlags, .rxPcsReady, .localFaultStatus, .rxSoftResetReq, .fifoFault);
  link_partner_model link_partner_model_i (.dropSig, .dropMarker, .errLanes, .unlockLanes,
    .badClk, .flagsCmd, .laneStatus, .markerLock, .signalDetect, .pmaFlags);

  // 200 MHz clock.
  always #2.5 core_clk = ~core_clk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset values, read-only protection and an unmapped index.
  task automatic t_regs();
    apb(1'b0, PMA_FLAG_SELECT_IDX, 0);
    check("flagSelect", rd, SELECT_RESET);
    apb(1'b0, LINK_CONTROL_IDX, 0);
    check("faultGen", rd[FAULT_GEN_EN_BIT], FAULT_GEN_RESET);
    apb(1'b1, RX_ALIGN_STATUS_IDX, 0);
    apb(1'b0, RX_ALIGN_STATUS_IDX, 0);
    check("alignRo", rd[ALIGN_BIT], 1'b1);
    check("mappedErr", err, 1'b0);
    apb(1'b1, 10'h3ff, 32'hffff_ffff);
    check("unmappedWrErr", err, 1'b1);
    apb(1'b0, 10'h3ff, 0);
    check("unmappedErr", err, 1'b1);
    check("unmappedData", rd, 0);
  endtask

  // Sticky framing errors, then the one-then-zero clear sequence.
  task automatic t_frame();
    errLanes <= 4'h1;
    unlockLanes <= 4'h8;
    @(posedge core_clk);
    errLanes <= 4'h0;
    unlockLanes <= 4'h0;
    apb(1'b0, FRAME_ERR_STATUS_IDX, 0);
    check("frameSticky", rd, 32'h9);
    apb(1'b1, FRAME_ERR_CLEAR_IDX, 1);
    errLanes <= 4'h2;
    apb(1'b0, FRAME_ERR_STATUS_IDX, 0);
    check("frameHeld", rd, 0);
    errLanes <= 4'h0;
    apb(1'b1, FRAME_ERR_CLEAR_IDX, 0);
    apb(1'b0, FRAME_ERR_STATUS_IDX, 0);
    check("frameLocked", rd, 0);
  endtask

  // Recovered clock lock per lane.
  task automatic t_clock();
    badClk <= 4'h2;
    apb(1'b0, RECOVERED_CLK_LCK_IDX, 0);
    check("clkLockBad", rd, 32'hd);
    badClk <= 4'h0;
    apb(1'b0, RECOVERED_CLK_LCK_IDX, 0);
    check("clkLockOk", rd, 32'hf);
  endtask

  // Selected flags only, and which extremes count as faults.
  task automatic t_flags();
    flagsCmd <= {4'b0000, 4'b0010, 4'b0000, 4'b0001};
    apb(1'b1, PMA_FLAG_SELECT_IDX, 32'h4);
    apb(1'b0, PMA_FLAGS_IDX, 0);
    check("flagsLane2", rd, 32'h200);
    check("rxFullFault", fifoFault, 1'b1);
    flagsCmd <= {4'b0000, 4'b0000, 4'b0000, 4'b0001};
    apb(1'b1, PMA_FLAG_SELECT_IDX, 32'h1);
    apb(1'b0, PMA_FLAGS_IDX, 0);
    check("flagsLane0", rd, 32'h1);
    check("rxEmptyOk", fifoFault, 1'b0);
    flagsCmd <= {4'b1000, 4'b0000, 4'b0000, 4'b0000};
    apb(1'b1, PMA_FLAG_SELECT_IDX, 0);
    apb(1'b0, PMA_FLAGS_IDX, 0);
    check("flagsNone", rd, 0);
    check("txFullFault", fifoFault, 1'b1);
    // Transmit empty on lane 1 alone is a fault; lane 3 only shows an empty RX FIFO.
    flagsCmd <= {4'b0001, 4'b0000, 4'b0100, 4'b0000};
    apb(1'b1, PMA_FLAG_SELECT_IDX, 32'ha);
    apb(1'b0, PMA_FLAGS_IDX, 0);
    check("flagsLane13", rd, 32'h1040);
    check("txEmptyFault", fifoFault, 1'b1);
    flagsCmd <= '0;
  endtask

  // Loss of signal or of marker lock from an established link, then recovery.
  task automatic t_loss(input logic gen, input logic marker);
    int hi;
    apb(1'b1, LINK_CONTROL_IDX, {31'h0, gen});
    hi = 0;
    if (marker) dropMarker <= 1'b1;
    else dropSig <= 1'b1;
    repeat (40)
    begin
      @(posedge core_clk);
      if (rxSoftResetReq === 1'b1) hi++;
    end
    check("softRstLen", hi, SOFT_RST_COUNT);
    check("readyLow", rxPcsReady, 1'b0);
    check("localFault", localFaultStatus, gen);
    check("txUntouched", fifoFault, 1'b0);
    apb(1'b0, RX_ALIGN_STATUS_IDX, 0);
    check("alignLow", rd[ALIGN_BIT], 1'b0);
    apb(1'b0, FAULT_REPORT_IDX, 0);
    check("faultBit", rd[LOCAL_FAULT_BIT], gen);
    dropSig <= 1'b0;
    dropMarker <= 1'b0;
    repeat (8) @(posedge core_clk);
    check("readyBack", rxPcsReady, 1'b1);
    check("faultGone", localFaultStatus, 1'b0);
    apb(1'b0, RX_ALIGN_STATUS_IDX, 0);
    check("alignBack", rd[ALIGN_BIT], 1'b1);
  endtask

  // Reset in the middle of a soft reset pulse; the loss ends one edge before release
  // so that no check sees a loss sampled under reset with a result taken after it.
  task automatic t_reset();
    apb(1'b1, PMA_FLAG_SELECT_IDX, 32'h5);
    apb(1'b1, LINK_CONTROL_IDX, 32'h0);
    dropSig <= 1'b1;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    check("rstSoftReq", rxSoftResetReq, 1'b0);
    check("rstReady", rxPcsReady, 1'b0);
    dropSig <= 1'b0;
    @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("rstReadyBack", rxPcsReady, 1'b1);
    check("rstFault", localFaultStatus, 1'b0);
    apb(1'b0, PMA_FLAG_SELECT_IDX, 0);
    check("rstSelect", rd, SELECT_RESET);
    apb(1'b0, LINK_CONTROL_IDX, 0);
    check("rstFaultGen", rd[FAULT_GEN_EN_BIT], FAULT_GEN_RESET);
  endtask

  task automatic tally_and_finish();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence; the link needs a few quiet cycles to come up after reset.
  initial
  begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_regs();
    t_frame();
    t_clock();
    t_flags();
    t_loss(1'b1, 1'b0);
    t_loss(1'b0, 1'b1);
    t_reset();
    tally_and_finish();
  end

  // The whole run needs well under a thousand cycles; this cuts a hang short.
  initial
  begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end
endmodule
